/* core/pfac_pkg.sv */
// constants and types shared by both ends of the program flash access link
package pfac_pkg;
	localparam int PAGE_WORDS = 128;
	localparam int PAGE_AW = 7;
	localparam logic [PAGE_AW-1:0] PAGE_LAST = 7'h7f;
	localparam int PM_AW = 16;
	localparam int DM_AW = 12;
	localparam int FD_WORDS = 4;
	localparam logic [7:0] TBL_HI_MASK = 8'hff;
	localparam logic [7:0] LAST_PAGE = 8'hff;
	localparam logic [1:0] TBL_CYCLES = 2'h2;
	// register indices on the link
	localparam logic [3:0] REG_FARL = 4'h0;
	localparam logic [3:0] REG_FARH = 4'h1;
	localparam logic [3:0] REG_FD0L = 4'h2;
	localparam logic [3:0] REG_FD0HI = 4'h3;
	localparam logic [3:0] REG_FCR = 4'ha;
	localparam logic [3:0] REG_FRCR = 4'hb;
	localparam logic [3:0] REG_THOLD = 4'hc;
	localparam logic [7:0] REG_RST = 8'h00;
	// control register bit positions
	localparam int FCR_EWEN = 7;
	localparam int FCR_FMOD_LO = 4;
	localparam int FCR_BWT = 3;
	localparam int FCR_WBUSY = 2;
	localparam int FCR_RDEN = 1;
	localparam int FCR_RBUSY = 0;
	localparam int FRCR_CLWB = 0;
	localparam logic [2:0] FMOD_WRITE = 3'h0;
	localparam logic [2:0] FMOD_ERASE = 3'h1;
	localparam logic [2:0] FMOD_ENABLE = 3'h6;
	// serial frame: 16 address bits in, 16 data bits out
	localparam logic [5:0] SER_ADDR_BITS = 6'h10;
	localparam logic [5:0] SER_FRAME_BITS = 6'h20;
	localparam logic [3:0] SER_HALF = 4'h8;
	typedef enum logic [1:0] {
		TBL_PAGED     = 2'b00,
		TBL_LAST      = 2'b01,
		TBL_EXT_PAGED = 2'b10,
		TBL_EXT_LAST  = 2'b11
	} pfac_tbl_kind_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_WAIT  = 2'b10,
		ST_CLEAR = 2'b11
	} pfac_state_t;
	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_TBL  = 2'b01,
		SRC_SER  = 2'b10,
		SRC_WRD  = 2'b11
	} pfac_src_t;
endpackage : pfac_pkg

/* core/pfac_link_if.sv */
// link between the cpu side and the program flash access logic
`timescale 1ns/1ns
interface pfac_link_if;
	logic                     tbl_req;
	pfac_pkg::pfac_tbl_kind_t tbl_kind;
	logic [7:0]               tbl_ptr_lo;
	logic [7:0]               tbl_ptr_hi;
	logic [11:0]              tbl_dst;
	logic                     tbl_done;
	logic [11:0]              tbl_wr_addr;
	logic [7:0]               tbl_wr_data;
	logic [7:0]               table_high_byte_holding;
	logic                     reg_wr;
	logic                     reg_rd;
	logic [3:0]               reg_idx;
	logic [7:0]               reg_wdata;
	logic                     reg_rvalid;
	logic [7:0]               reg_rdata;
	logic                     prog_serial_clock_pin;
	logic                     sda_host_o;
	logic                     sda_host_oe;
	logic                     sda_dev_o;
	logic                     sda_dev_oe;
	logic                     prog_serial_data_pin;
	// pulled high when nobody drives
	assign prog_serial_data_pin = sda_host_oe ? sda_host_o : (sda_dev_oe ? sda_dev_o : 1'b1);
	modport device (
		input  tbl_req, tbl_kind, tbl_ptr_lo, tbl_ptr_hi, tbl_dst,
		output tbl_done, tbl_wr_addr, tbl_wr_data, table_high_byte_holding,
		input  reg_wr, reg_rd, reg_idx, reg_wdata,
		output reg_rvalid, reg_rdata,
		input  prog_serial_clock_pin, prog_serial_data_pin,
		output sda_dev_o, sda_dev_oe
	);
	modport host (
		output tbl_req, tbl_kind, tbl_ptr_lo, tbl_ptr_hi, tbl_dst,
		input  tbl_done, tbl_wr_addr, tbl_wr_data, table_high_byte_holding,
		output reg_wr, reg_rd, reg_idx, reg_wdata,
		input  reg_rvalid, reg_rdata,
		output prog_serial_clock_pin, sda_host_o, sda_host_oe,
		input  prog_serial_data_pin
	);
endinterface : pfac_link_if

/* core/pfac_device.sv */
// program flash access logic: table reads, page erase/write, word read, serial port
`timescale 1ns/1ns
module pfac_device (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// link to cpu side
	pfac_link_if.device      lnk,
	// flash array
	output logic             fl_rd_o,
	output logic [15:0]      fl_raddr_o,
	input  wire logic [15:0] fl_rdata_i,
	output logic             fl_wr_o,
	output logic             fl_erase_o,
	output logic [15:0]      fl_waddr_o,
	output logic [15:0]      fl_wdata_o,
	input  wire logic        fl_busy_i,
	// status
	output logic             erase_write_enabled_flag_o
);
	logic [15:0]               far_q;
	logic [7:0]                fdl_q [pfac_pkg::FD_WORDS];
	logic [7:0]                fdh_q [pfac_pkg::FD_WORDS];
	logic [15:0]               wbuf_q [pfac_pkg::PAGE_WORDS];
	logic                      ewen_q, wbusy_q, rden_q, rbusy_q, bwt_q, clwb_q;
	logic [2:0]                fmod_q;
	logic [2:0]                frcr_hi_q;
	logic [7:0]                thold_q;
	logic [7:0]                rdata_q;
	logic                      rvalid_q;
	pfac_pkg::pfac_state_t     state_q;
	logic [pfac_pkg::PAGE_AW-1:0] wr_idx_q;
	logic                      is_wr_q, fl_wr_q, fl_erase_q;
	logic [15:0]               fl_waddr_q, fl_wdata_q;
	pfac_pkg::pfac_src_t       src_q;
	logic                      wrd_wait_q;
	logic [11:0]               tbl_dst_q;
	logic [7:0]                tbl_data_q;
	logic                      tbl_done_q;
	logic                      sck_m_q, sck_s_q, sck_d_q, sda_m_q, sda_s_q;
	logic [5:0]                bit_cnt_q;
	logic [15:0]               ser_in_q, ser_addr_q, ser_out_q;
	logic                      ser_pend_q, sda_o_q, sda_oe_q;

	logic       wr, wr_fcr, start_ok, buf_ld, clr_buf, op_done;
	logic       wrd_go, ser_go, ret_tbl, ret_ser, ret_wrd, sck_rise, sck_fall;
	logic [2:0] wmode;
	logic [7:0] page_sel;

	assign wr       = lnk.reg_wr;
	assign wr_fcr   = wr && lnk.reg_idx == pfac_pkg::REG_FCR;
	assign wmode    = lnk.reg_wdata[pfac_pkg::FCR_FMOD_LO +: 3];
	assign start_ok = state_q == pfac_pkg::ST_IDLE && ewen_q && !wbusy_q
		&& (wmode == pfac_pkg::FMOD_WRITE || wmode == pfac_pkg::FMOD_ERASE);
	// loads during a page write would corrupt the page in flight
	assign buf_ld   = wr && lnk.reg_idx == pfac_pkg::REG_FD0HI && ewen_q
		&& state_q == pfac_pkg::ST_IDLE;
	assign clr_buf  = clwb_q || state_q == pfac_pkg::ST_CLEAR;
	assign op_done  = state_q == pfac_pkg::ST_CLEAR || (state_q == pfac_pkg::ST_WAIT
		&& !is_wr_q && !fl_busy_i && !fl_erase_q);

	// read port: table first, then serial, then control word read
	assign ser_go  = ser_pend_q && !lnk.tbl_req;
	assign wrd_go  = rbusy_q && rden_q && !wrd_wait_q && !lnk.tbl_req && !ser_pend_q;
	assign fl_rd_o = lnk.tbl_req || ser_go || wrd_go;
	assign page_sel = (lnk.tbl_kind == pfac_pkg::TBL_LAST || lnk.tbl_kind == pfac_pkg::TBL_EXT_LAST)
		? pfac_pkg::LAST_PAGE : lnk.tbl_ptr_hi;
	always_comb begin
		if (lnk.tbl_req) begin
			fl_raddr_o = {page_sel, lnk.tbl_ptr_lo};
		end else if (ser_go) begin
			fl_raddr_o = ser_addr_q;
		end else begin
			fl_raddr_o = far_q;
		end
	end
	assign ret_tbl = src_q == pfac_pkg::SRC_TBL;
	assign ret_ser = src_q == pfac_pkg::SRC_SER;
	assign ret_wrd = src_q == pfac_pkg::SRC_WRD;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			src_q <= pfac_pkg::SRC_NONE;
		end else if (lnk.tbl_req) begin
			src_q <= pfac_pkg::SRC_TBL;
		end else if (ser_go) begin
			src_q <= pfac_pkg::SRC_SER;
		end else if (wrd_go) begin
			src_q <= pfac_pkg::SRC_WRD;
		end else begin
			src_q <= pfac_pkg::SRC_NONE;
		end
	end

	// table read: request cycle, data cycle, done two cycles after request
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tbl_dst_q  <= 12'h000;
			tbl_data_q <= 8'h00;
			tbl_done_q <= 1'b0;
		end else begin
			tbl_done_q <= ret_tbl;
			if (lnk.tbl_req) begin
				if (lnk.tbl_kind == pfac_pkg::TBL_EXT_PAGED || lnk.tbl_kind == pfac_pkg::TBL_EXT_LAST) begin
					tbl_dst_q <= lnk.tbl_dst;
				end else begin
					tbl_dst_q <= {4'h0, lnk.tbl_dst[7:0]};
				end
			end
			if (ret_tbl) begin
				tbl_data_q <= fl_rdata_i[7:0];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			thold_q <= pfac_pkg::REG_RST;
		end else if (ret_tbl) begin
			thold_q <= fl_rdata_i[15:8] & pfac_pkg::TBL_HI_MASK;
		end else if (wr && lnk.reg_idx == pfac_pkg::REG_THOLD) begin
			thold_q <= lnk.reg_wdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			far_q <= 16'h0000;
		end else if (wr && lnk.reg_idx == pfac_pkg::REG_FARL) begin
			far_q[7:0] <= lnk.reg_wdata;
		end else if (wr && lnk.reg_idx == pfac_pkg::REG_FARH) begin
			far_q[15:8] <= lnk.reg_wdata;
		end else if (buf_ld && far_q[pfac_pkg::PAGE_AW-1:0] != pfac_pkg::PAGE_LAST) begin
			far_q[pfac_pkg::PAGE_AW-1:0] <= far_q[pfac_pkg::PAGE_AW-1:0] + 7'h01;
		end
	end

	for (genvar n = 0; n < pfac_pkg::FD_WORDS; n++) begin : g_fd
		always_ff @(posedge mclk_i) begin
			if (reset_i) begin
				fdl_q[n] <= pfac_pkg::REG_RST;
				fdh_q[n] <= pfac_pkg::REG_RST;
			end else if (n == 0 && ret_wrd) begin
				fdl_q[n] <= fl_rdata_i[7:0];
				fdh_q[n] <= fl_rdata_i[15:8];
			end else if (wr && lnk.reg_idx == 4'(pfac_pkg::REG_FD0L + 2 * n)) begin
				fdl_q[n] <= lnk.reg_wdata;
			end else if (wr && lnk.reg_idx == 4'(pfac_pkg::REG_FD0HI + 2 * n)) begin
				fdh_q[n] <= lnk.reg_wdata;
			end
		end
	end

	for (genvar w = 0; w < pfac_pkg::PAGE_WORDS; w++) begin : g_wbuf
		always_ff @(posedge mclk_i) begin
			if (reset_i || clr_buf) begin
				wbuf_q[w] <= 16'h0000;
			end else if (buf_ld && far_q[pfac_pkg::PAGE_AW-1:0] == 7'(w)) begin
				wbuf_q[w] <= {lnk.reg_wdata, fdl_q[0]};
			end
		end
	end

	// control bits: a software set wins over the hardware clear of the same cycle
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ewen_q  <= 1'b0;
			wbusy_q <= 1'b0;
			rbusy_q <= 1'b0;
			rden_q  <= 1'b0;
			bwt_q   <= 1'b0;
			fmod_q  <= 3'h0;
		end else begin
			if (op_done) begin
				wbusy_q <= 1'b0;
			end
			if (ret_wrd || (rbusy_q && !rden_q)) begin
				rbusy_q <= 1'b0;
			end
			if (wr_fcr) begin
				rden_q <= lnk.reg_wdata[pfac_pkg::FCR_RDEN];
				bwt_q  <= lnk.reg_wdata[pfac_pkg::FCR_BWT];
				fmod_q <= wmode;
				if (!lnk.reg_wdata[pfac_pkg::FCR_EWEN]) begin
					ewen_q <= 1'b0;
				end
				if (lnk.reg_wdata[pfac_pkg::FCR_WBUSY] && wmode == pfac_pkg::FMOD_ENABLE) begin
					ewen_q <= 1'b1;
				end
				if (lnk.reg_wdata[pfac_pkg::FCR_WBUSY] && start_ok) begin
					wbusy_q <= 1'b1;
				end
				if (lnk.reg_wdata[pfac_pkg::FCR_RBUSY]) begin
					rbusy_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wrd_wait_q <= 1'b0;
		end else if (wrd_go) begin
			wrd_wait_q <= 1'b1;
		end else if (ret_wrd) begin
			wrd_wait_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			clwb_q    <= 1'b0;
			frcr_hi_q <= 3'h0;
		end else if (wr && lnk.reg_idx == pfac_pkg::REG_FRCR) begin
			clwb_q    <= lnk.reg_wdata[pfac_pkg::FRCR_CLWB];
			frcr_hi_q <= {lnk.reg_wdata[7:6], lnk.reg_wdata[4]};
		end else begin
			clwb_q <= 1'b0;
		end
	end

	// page engine: erase pulses once, write streams the whole buffer
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_q    <= pfac_pkg::ST_IDLE;
			wr_idx_q   <= 7'h00;
			is_wr_q    <= 1'b0;
			fl_wr_q    <= 1'b0;
			fl_erase_q <= 1'b0;
			fl_waddr_q <= 16'h0000;
			fl_wdata_q <= 16'h0000;
		end else begin
			fl_wr_q    <= 1'b0;
			fl_erase_q <= 1'b0;
			case (state_q)
				pfac_pkg::ST_IDLE: begin
					wr_idx_q <= 7'h00;
					if (wr_fcr && lnk.reg_wdata[pfac_pkg::FCR_WBUSY] && start_ok) begin
						is_wr_q <= wmode == pfac_pkg::FMOD_WRITE;
						if (wmode == pfac_pkg::FMOD_WRITE) begin
							state_q <= pfac_pkg::ST_WRITE;
						end else begin
							fl_erase_q <= 1'b1;
							fl_waddr_q <= {far_q[15:pfac_pkg::PAGE_AW], 7'h00};
							state_q    <= pfac_pkg::ST_WAIT;
						end
					end
				end
				pfac_pkg::ST_WRITE: begin
					if (!fl_busy_i && !fl_wr_q) begin
						fl_wr_q    <= 1'b1;
						fl_waddr_q <= {far_q[15:pfac_pkg::PAGE_AW], wr_idx_q};
						fl_wdata_q <= wbuf_q[wr_idx_q];
						wr_idx_q   <= wr_idx_q + 7'h01;
						if (wr_idx_q == pfac_pkg::PAGE_LAST) begin
							state_q <= pfac_pkg::ST_WAIT;
						end
					end
				end
				pfac_pkg::ST_WAIT: begin
					if (!fl_busy_i && !fl_wr_q && !fl_erase_q) begin
						state_q <= is_wr_q ? pfac_pkg::ST_CLEAR : pfac_pkg::ST_IDLE;
					end
				end
				pfac_pkg::ST_CLEAR: begin
					state_q <= pfac_pkg::ST_IDLE;
				end
				default: begin
					state_q <= pfac_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_q  <= pfac_pkg::REG_RST;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= lnk.reg_rd;
			case (lnk.reg_idx)
				pfac_pkg::REG_FARL: rdata_q <= far_q[7:0];
				pfac_pkg::REG_FARH: rdata_q <= far_q[15:8];
				4'h2, 4'h4, 4'h6, 4'h8: rdata_q <= fdl_q[lnk.reg_idx[2:1] - 2'h1];
				4'h3, 4'h5, 4'h7, 4'h9: rdata_q <= fdh_q[lnk.reg_idx[2:1] - 2'h1];
				pfac_pkg::REG_FCR: rdata_q <= {ewen_q, fmod_q, bwt_q, wbusy_q, rden_q, rbusy_q};
				pfac_pkg::REG_FRCR: rdata_q <= {frcr_hi_q[2:1], 1'b0, frcr_hi_q[0], 3'h0, clwb_q};
				pfac_pkg::REG_THOLD: rdata_q <= thold_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// serial port; the clock pin is only ever sampled, never driven
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_d_q <= 1'b0;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			sck_m_q <= lnk.prog_serial_clock_pin;
			sck_s_q <= sck_m_q;
			sck_d_q <= sck_s_q;
			sda_m_q <= lnk.prog_serial_data_pin;
			sda_s_q <= sda_m_q;
		end
	end
	assign sck_rise = sck_s_q && !sck_d_q;
	assign sck_fall = !sck_s_q && sck_d_q;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			bit_cnt_q  <= 6'h00;
			ser_in_q   <= 16'h0000;
			ser_addr_q <= 16'h0000;
			ser_pend_q <= 1'b0;
			ser_out_q  <= 16'h0000;
			sda_o_q    <= 1'b1;
			sda_oe_q   <= 1'b0;
		end else begin
			if (ser_go) begin
				ser_pend_q <= 1'b0;
			end
			if (sck_rise) begin
				bit_cnt_q <= (bit_cnt_q == pfac_pkg::SER_FRAME_BITS - 6'h01) ? 6'h00 : bit_cnt_q + 6'h01;
				if (bit_cnt_q < pfac_pkg::SER_ADDR_BITS) begin
					ser_in_q <= {ser_in_q[14:0], sda_s_q};
				end
				if (bit_cnt_q == pfac_pkg::SER_ADDR_BITS - 6'h01) begin
					ser_addr_q <= {ser_in_q[14:0], sda_s_q};
					ser_pend_q <= 1'b1;
				end
				if (bit_cnt_q == pfac_pkg::SER_FRAME_BITS - 6'h01) begin
					sda_oe_q <= 1'b0;
				end
			end
			if (ret_ser) begin
				ser_out_q <= fl_rdata_i;
			end else if (sck_fall && bit_cnt_q >= pfac_pkg::SER_ADDR_BITS) begin
				sda_o_q   <= ser_out_q[15];
				sda_oe_q  <= 1'b1;
				ser_out_q <= {ser_out_q[14:0], 1'b0};
			end
		end
	end

	assign lnk.tbl_done                = tbl_done_q;
	assign lnk.tbl_wr_addr             = tbl_dst_q;
	assign lnk.tbl_wr_data             = tbl_data_q;
	assign lnk.table_high_byte_holding = thold_q;
	assign lnk.reg_rvalid              = rvalid_q;
	assign lnk.reg_rdata               = rdata_q;
	assign lnk.sda_dev_o               = sda_o_q;
	assign lnk.sda_dev_oe              = sda_oe_q;
	assign fl_wr_o                     = fl_wr_q;
	assign fl_erase_o                  = fl_erase_q;
	assign fl_waddr_o                  = fl_waddr_q;
	assign fl_wdata_o                  = fl_wdata_q;
	assign erase_write_enabled_flag_o  = ewen_q;
endmodule : pfac_device

/* core/pfac_host.sv */
// cpu side end: table read sequencing, register access, serial programmer
`timescale 1ns/1ns
module pfac_host (
	// clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     reset_i,
	// link to flash access logic
	pfac_link_if.host                     lnk,
	// table read request from the pipeline
	input  wire logic                     tbl_req_i,
	input  wire pfac_pkg::pfac_tbl_kind_t tbl_kind_i,
	input  wire logic [7:0]               tbl_ptr_lo_i,
	input  wire logic [7:0]               tbl_ptr_hi_i,
	input  wire logic [11:0]              tbl_dst_i,
	output logic                          stall_o,
	output logic                          tbl_done_o,
	output logic [11:0]                   tbl_wr_addr_o,
	output logic [7:0]                    tbl_wr_data_o,
	// register access
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	input  wire logic [3:0]               reg_idx_i,
	input  wire logic [7:0]               reg_wdata_i,
	output logic                          reg_rvalid_o,
	output logic [7:0]                    reg_rdata_o,
	// serial word read
	input  wire logic                     ser_start_i,
	input  wire logic [15:0]              ser_addr_i,
	output logic                          ser_busy_o,
	output logic                          ser_done_o,
	output logic [15:0]                   ser_data_o
);
	logic [1:0]  tbl_cnt_q;
	logic        tbl_take;
	logic        rvalid_q, tdone_q;
	logic [7:0]  rdata_q, twdata_q;
	logic [11:0] twaddr_q;
	logic        run_q, sck_q, sda_o_q, sda_oe_q, done_q;
	logic [3:0]  div_q;
	logic [5:0]  cnt_q;
	logic [15:0] tx_q, rx_q;
	logic        sda_m_q, sda_s_q;
	logic        tick;

	// a table instruction holds the pipeline from its request cycle until the device's done, two cycles later
	assign tbl_take = tbl_req_i && tbl_cnt_q == 2'h0;
	assign stall_o  = tbl_req_i || tbl_cnt_q != 2'h0;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tbl_cnt_q <= 2'h0;
		end else if (tbl_take) begin
			tbl_cnt_q <= pfac_pkg::TBL_CYCLES - 2'h1;
		end else if (tbl_cnt_q != 2'h0 && !lnk.tbl_done) begin
			tbl_cnt_q <= tbl_cnt_q;
		end else begin
			tbl_cnt_q <= 2'h0;
		end
	end
	assign lnk.tbl_req    = tbl_take;
	assign lnk.tbl_kind   = tbl_kind_i;
	assign lnk.tbl_ptr_lo = tbl_ptr_lo_i;
	assign lnk.tbl_ptr_hi = tbl_ptr_hi_i;
	assign lnk.tbl_dst    = tbl_dst_i;
	assign lnk.reg_wr     = reg_wr_i;
	assign lnk.reg_rd     = reg_rd_i;
	assign lnk.reg_idx    = reg_idx_i;
	assign lnk.reg_wdata  = reg_wdata_i;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tdone_q  <= 1'b0;
			twaddr_q <= 12'h000;
			twdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
		end else begin
			tdone_q  <= lnk.tbl_done;
			rvalid_q <= lnk.reg_rvalid;
			if (lnk.tbl_done) begin
				twaddr_q <= lnk.tbl_wr_addr;
				twdata_q <= lnk.tbl_wr_data;
			end
			if (lnk.reg_rvalid) begin
				rdata_q <= lnk.reg_rdata;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			sda_m_q <= lnk.prog_serial_data_pin;
			sda_s_q <= sda_m_q;
		end
	end

	// programmer clock: half period of SER_HALF cycles, low when idle
	assign tick = run_q && div_q == pfac_pkg::SER_HALF - 4'h1;
	always_ff @(posedge mclk_i) begin
		if (reset_i || !run_q || tick) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			run_q    <= 1'b0;
			sck_q    <= 1'b0;
			sda_o_q  <= 1'b1;
			sda_oe_q <= 1'b0;
			cnt_q    <= 6'h00;
			tx_q     <= 16'h0000;
			rx_q     <= 16'h0000;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!run_q && ser_start_i) begin
				run_q    <= 1'b1;
				cnt_q    <= 6'h00;
				sda_o_q  <= ser_addr_i[15];
				sda_oe_q <= 1'b1;
				tx_q     <= {ser_addr_i[14:0], 1'b0};
			end else if (tick && !sck_q) begin
				sck_q <= 1'b1;
				cnt_q <= cnt_q + 6'h01;
				if (cnt_q >= pfac_pkg::SER_ADDR_BITS) begin
					rx_q <= {rx_q[14:0], sda_s_q};
				end
			end else if (tick) begin
				sck_q <= 1'b0;
				if (cnt_q < pfac_pkg::SER_ADDR_BITS) begin
					sda_o_q <= tx_q[15];
					tx_q    <= {tx_q[14:0], 1'b0};
				end else begin
					sda_oe_q <= 1'b0;
				end
				if (cnt_q == pfac_pkg::SER_FRAME_BITS) begin
					run_q  <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end
	assign lnk.prog_serial_clock_pin = sck_q;
	assign lnk.sda_host_o            = sda_o_q;
	assign lnk.sda_host_oe           = sda_oe_q;

	assign tbl_done_o    = tdone_q;
	assign tbl_wr_addr_o = twaddr_q;
	assign tbl_wr_data_o = twdata_q;
	assign reg_rvalid_o  = rvalid_q;
	assign reg_rdata_o   = rdata_q;
	assign ser_busy_o    = run_q;
	assign ser_done_o    = done_q;
	assign ser_data_o    = rx_q;
endmodule : pfac_host

/* dv/pfac_link_assertions.sv */
// concurrent checks on the link between the two ends
`timescale 1ns/1ns
module pfac_link_assertions (
	// clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     reset_i,
	// table link
	input  wire logic                     tbl_req,
	input  wire pfac_pkg::pfac_tbl_kind_t tbl_kind,
	input  wire logic [11:0]              tbl_dst,
	input  wire logic                     tbl_done,
	input  wire logic [11:0]              tbl_wr_addr,
	input  wire logic [7:0]               table_high_byte_holding,
	// register and serial link
	input  wire logic                     reg_rd,
	input  wire logic                     reg_rvalid,
	input  wire logic                     sda_host_oe,
	input  wire logic                     sda_dev_oe
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	sequence s_req;
		tbl_req;
	endsequence
	sequence s_ext_req;
		tbl_req && tbl_kind[1];
	endsequence
	sequence s_answer;
		##2 tbl_done;
	endsequence
	a_tbl_two_cycles: assert property (s_req |-> s_answer)
		else $error("table answer not two cycles after request");
	a_done_has_req: assert property (tbl_done |-> $past(tbl_req, 2))
		else $error("table answer without request");
	a_hi_unused_zero: assert property (tbl_done |->
		(table_high_byte_holding & ~pfac_pkg::TBL_HI_MASK) == 8'h00)
		else $error("unused high byte bits not zero");
	a_sector_zero_dst: assert property (tbl_req && !tbl_kind[1] |-> ##2
		tbl_wr_addr[11:8] == 4'h0) else $error("short form left sector zero");
	a_ext_dst_kept: assert property (s_ext_req |-> ##2 tbl_wr_addr == $past(tbl_dst, 2))
		else $error("extended form lost its destination");
	a_reg_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("register read not answered");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("register answer without read");
	a_one_driver: assert property (!(sda_host_oe && sda_dev_oe))
		else $error("both ends drive the data pin");
	a_dev_turnaround: assert property ($rose(sda_dev_oe) |-> $past(!sda_host_oe))
		else $error("device drove before host let go");
endmodule : pfac_link_assertions

/* dv/testbench.sv */
// self-checking bench joining both ends of the flash access link
`timescale 1ns/1ns
module testbench;
	logic                     mclk_i = 1'b0, reset_i = 1'b1, tbl_req_i = 1'b0, ser_start_i = 1'b0;
	logic                     reg_wr_i = 1'b0, reg_rd_i = 1'b0, fl_busy_i = 1'b0;
	pfac_pkg::pfac_tbl_kind_t tbl_kind_i = pfac_pkg::TBL_PAGED;
	logic [7:0]               tbl_ptr_lo_i = 8'h00, tbl_ptr_hi_i = 8'h00, reg_wdata_i = 8'h00, v;
	logic [11:0]              tbl_dst_i = 12'h000;
	logic [3:0]               reg_idx_i = 4'h0;
	logic [15:0]              ser_addr_i = 16'h0000, fl_rdata_i = 16'h0000;
	logic [15:0]              n_wr = 16'h0000, n_er = 16'h0000, last_w = 16'h0000;
	logic                     tbl_done_o, reg_rvalid_o, ser_done_o, fl_wr_o, fl_erase_o, ew_flag;
	logic [11:0]              tbl_wr_addr_o;
	logic [7:0]               tbl_wr_data_o, reg_rdata_o;
	logic [15:0]              ser_data_o, fl_raddr_o, fl_waddr_o, fl_wdata_o;
	logic                     fl_rd_o, stall, ser_busy;
	int                       n_mismatch = 0, num_checks = 0;
	pfac_link_if lnk ();
	pfac_host pfac_host_inst (.mclk_i(mclk_i), .reset_i(reset_i), .lnk(lnk), .stall_o(stall),
		.tbl_req_i(tbl_req_i), .tbl_kind_i(tbl_kind_i), .tbl_ptr_lo_i(tbl_ptr_lo_i),
		.tbl_ptr_hi_i(tbl_ptr_hi_i), .tbl_dst_i(tbl_dst_i), .tbl_done_o(tbl_done_o),
		.tbl_wr_addr_o(tbl_wr_addr_o), .tbl_wr_data_o(tbl_wr_data_o), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
		.reg_rvalid_o(reg_rvalid_o), .reg_rdata_o(reg_rdata_o), .ser_start_i(ser_start_i),
		.ser_addr_i(ser_addr_i), .ser_busy_o(ser_busy), .ser_done_o(ser_done_o),
		.ser_data_o(ser_data_o));
	pfac_device pfac_device_inst (.mclk_i(mclk_i), .reset_i(reset_i), .lnk(lnk), .fl_rd_o(fl_rd_o),
		.fl_raddr_o(fl_raddr_o), .fl_rdata_i(fl_rdata_i), .fl_wr_o(fl_wr_o),
		.fl_erase_o(fl_erase_o), .fl_waddr_o(fl_waddr_o), .fl_wdata_o(fl_wdata_o),
		.fl_busy_i(fl_busy_i), .erase_write_enabled_flag_o(ew_flag));
	pfac_link_assertions pfac_link_assertions_inst (.mclk_i(mclk_i), .reset_i(reset_i),
		.tbl_req(lnk.tbl_req), .tbl_kind(lnk.tbl_kind), .tbl_dst(lnk.tbl_dst),
		.tbl_done(lnk.tbl_done), .tbl_wr_addr(lnk.tbl_wr_addr),
		.table_high_byte_holding(lnk.table_high_byte_holding), .reg_rd(lnk.reg_rd),
		.reg_rvalid(lnk.reg_rvalid), .sda_host_oe(lnk.sda_host_oe), .sda_dev_oe(lnk.sda_dev_oe));
	always #2 mclk_i = ~mclk_i;
	// flash array stand-in: each word holds the inverse of its address
	always @(posedge mclk_i) begin
		if (fl_rd_o)
			fl_rdata_i <= ~fl_raddr_o;
		n_wr <= n_wr + {15'h0000, fl_wr_o};
		n_er <= n_er + {15'h0000, fl_erase_o};
		if (fl_wr_o && fl_waddr_o[6:0] == 7'h7e)
			last_w <= fl_wdata_o;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic reg_put(input logic [3:0] idx, input logic [7:0] d);
		@(negedge mclk_i);
		reg_wr_i = 1'b1;
		reg_idx_i = idx;
		reg_wdata_i = d;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
	endtask : reg_put
	task automatic reg_get(input logic [3:0] idx, output logic [7:0] d);
		@(negedge mclk_i);
		reg_rd_i = 1'b1;
		reg_idx_i = idx;
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
		for (int i = 0; i < 8 && reg_rvalid_o !== 1'b1; i++)
			@(negedge mclk_i);
		d = reg_rdata_o;
	endtask : reg_get
	task automatic tbl(input logic [1:0] k, input logic [7:0] hi, lo, input logic [11:0] dst);
		logic [7:0] pg;
		pg = k[0] ? pfac_pkg::LAST_PAGE : hi;
		@(negedge mclk_i);
		tbl_req_i = 1'b1;
		tbl_kind_i = pfac_pkg::pfac_tbl_kind_t'(k);
		tbl_ptr_hi_i = hi;
		tbl_ptr_lo_i = lo;
		tbl_dst_i = dst;
		@(negedge mclk_i);
		check(stall, 1'b1);
		tbl_req_i = 1'b0;
		for (int i = 0; i < 8 && tbl_done_o !== 1'b1; i++)
			@(negedge mclk_i);
		check(stall, 1'b0);
		check(tbl_wr_data_o, 8'(~lo));
		check(tbl_wr_addr_o, k[1] ? dst : {4'h0, dst[7:0]});
		reg_get(pfac_pkg::REG_THOLD, v);
		check(v, 8'(~pg));
	endtask : tbl
	task automatic pg_write(input logic [7:0] cmd);
		reg_put(pfac_pkg::REG_FCR, cmd);
		reg_get(pfac_pkg::REG_FCR, v);
		if (!cmd[4])
			check(v, cmd);
		for (int i = 0; i < 100 && v[2] !== 1'b0; i++)
			reg_get(pfac_pkg::REG_FCR, v);
		check(v, cmd & 8'hfb);
	endtask : pg_write
	initial begin
		repeat (5) @(negedge mclk_i);
		reset_i = 1'b0;
		for (int k = 0; k < 4; k++)
			tbl(k[1:0], 8'h12, 8'h34 + k[7:0], 12'h345);
		reg_put(pfac_pkg::REG_FARL, 8'h7e);
		reg_put(pfac_pkg::REG_FD0HI, 8'hbb);
		reg_get(pfac_pkg::REG_FARL, v);
		check(v, 8'h7e);
		reg_put(pfac_pkg::REG_FCR, 8'he4);
		@(negedge mclk_i);
		check(ew_flag, 1'b1);
		reg_put(pfac_pkg::REG_FD0L, 8'haa);
		reg_put(pfac_pkg::REG_FD0HI, 8'hbb);
		reg_put(pfac_pkg::REG_FD0HI, 8'hbb);
		reg_get(pfac_pkg::REG_FARL, v);
		check(v, 8'h7f);
		pg_write(8'h94);
		pg_write(8'h84);
		check(n_wr, 16'h0080);
		check(last_w, 16'hbbaa);
		pg_write(8'h94);
		pg_write(8'h84);
		check(last_w, 16'h0000);
		check(n_er, 16'h0002);
		reg_put(pfac_pkg::REG_FARL, 8'h11);
		reg_put(pfac_pkg::REG_FCR, 8'h83);
		repeat (3) @(negedge mclk_i);
		reg_get(pfac_pkg::REG_FCR, v);
		check(v, 8'h82);
		reg_get(pfac_pkg::REG_FD0L, v);
		check(v, 8'hee);
		reg_put(pfac_pkg::REG_FARL, 8'h22);
		reg_put(pfac_pkg::REG_FCR, 8'h81);
		repeat (3) @(negedge mclk_i);
		reg_get(pfac_pkg::REG_FCR, v);
		check(v, 8'h80);
		reg_get(pfac_pkg::REG_FD0L, v);
		check(v, 8'hee);
		@(negedge mclk_i);
		ser_addr_i = 16'h1234;
		ser_start_i = 1'b1;
		@(negedge mclk_i);
		ser_start_i = 1'b0;
		check(ser_busy, 1'b1);
		for (int i = 0; i < 2000 && ser_done_o !== 1'b1; i++)
			@(negedge mclk_i);
		check(ser_data_o, 16'hedcb);
		check(ser_busy, 1'b0);
		print_verdict();
	end
	// whole run is under two thousand cycles; this cuts a hang short
	initial begin
		#40000;
		n_mismatch++;
		print_verdict();
	end
endmodule : testbench
